// >>> csl_regs.svh
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
// Startup-source record word address in parameter flash
`define CSL_REC_ADDR       16'h0000
// Profile base addresses in parameter flash
`define CSL_FACTORY_BASE   16'h0100
`define CSL_USER_BASE      16'h0200
`define CSL_USER_STRIDE    16'h0100
// Selector field of the startup-source record
`define CSL_SEL_LSB        0
`define CSL_SEL_W          3
// Selector encodings
`define CSL_SEL_FACTORY    3'h0
`define CSL_SEL_USER0      3'h1
`define CSL_SEL_USER3      3'h4
// Number of settings words per profile
`define CSL_PROFILE_WORDS  8'h10
`endif

// >>> csl_pkg.sv
package csl_pkg;
  typedef enum logic [2:0] {
    CSL_PROFILE_FACTORY,
    CSL_PROFILE_USER0,
    CSL_PROFILE_USER1,
    CSL_PROFILE_USER2,
    CSL_PROFILE_USER3
  } csl_profile_type;
endpackage : csl_pkg

// >>> csl_flash_if.sv
`timescale 1ns/1ns
interface csl_flash_if;
  logic        req;
  logic [15:0] addr;
  logic        ack;
  logic [15:0] data;
  modport master (output req, output addr, input ack, input data);
  modport slave  (input req, input addr, output ack, output data);
endinterface : csl_flash_if

// >>> csl_flash_port.sv
`timescale 1ns/1ns
// Registers one parameter-flash read; result comes out of a flip-flop
module csl_flash_port (
  input  wire logic  clk,        // Core clock
  input  wire logic  rst_n,      // Sync reset
  csl_flash_if.slave fl,         // Read request side
  output logic       pf_req,     // Flash read strobe
  output logic [15:0] pf_addr,   // Flash address
  input  wire logic  pf_ack,     // Flash data valid
  input  wire logic [15:0] pf_data // Flash data
);
  logic busy_q;
  logic ack_q;
  logic [15:0] data_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      ack_q  <= 1'b0;
      data_q <= 16'h0000;
    end
    else
    begin
      ack_q <= 1'b0;
      if (fl.req && !busy_q && !ack_q)
        busy_q <= 1'b1;
      else if (busy_q && pf_ack)
      begin
        busy_q <= 1'b0;
        ack_q  <= 1'b1;
        data_q <= pf_data;
      end
    end
  end
  assign pf_req  = busy_q;
  assign pf_addr = fl.addr;
  assign fl.ack  = ack_q;
  assign fl.data = data_q;
endmodule : csl_flash_port

// >>> csl_loader.sv
`timescale 1ns/1ns
`include "csl_regs.svh"
// Behaviour
// RL1: Run full startup on power-up and on each full-restart command.
// RL2: First check program flash image; load it into logic when valid.
// RL3: Read startup-source record from parameter flash before any settings.
// RL4: Restore settings only from the profile the selector names.
// RL5: Profiles are factory (default) and user profiles 0 to 3.
// RL6: Accept host commands only once settings restore is finished.
// RL7: Full restart resets coax link engine and camera head.
// RL8: No valid image: stay in boot loader, skip restore, never report done.
module csl_loader (
  input  wire logic        CORE_CLK,      // 125 MHz core clock
  input  wire logic        RST_N,         // Power-up reset, sync, low
  input  wire logic        FULL_RESTART,  // Full-restart command pulse
  output logic             IMG_CHECK,     // Request image check
  input  wire logic        IMG_DONE,      // Image check finished
  input  wire logic        IMG_VALID,     // Image found valid
  output logic             IMG_LOAD,      // Request image load
  input  wire logic        IMG_LOADED,    // Image load finished
  output logic             PF_REQ,        // Parameter flash read strobe
  output logic [15:0]      PF_ADDR,       // Parameter flash address
  input  wire logic        PF_ACK,        // Parameter flash data valid
  input  wire logic [15:0] PF_DATA,       // Parameter flash data
  output logic             SET_WE,        // Settings word write
  output logic [7:0]       SET_IDX,       // Settings word index
  output logic [15:0]      SET_DATA,      // Settings word
  output logic [2:0]       PROFILE,       // Profile in use
  output logic             LINK_RST_N,    // Coax link engine reset
  output logic             HEAD_RST_N,    // Camera head reset
  output logic             BOOT_FAIL,     // Stuck in boot loader
  output logic             CMD_ENABLE     // Host commands accepted
);
  typedef enum {
    ST_RESET, ST_CHECK, ST_LOAD, ST_FAIL, ST_REC, ST_SET, ST_READY
  } csl_state_type;

  csl_state_type state_q;
  logic [7:0]    word_q;
  logic [15:0]   base_q;
  logic          rd_q;
  csl_pkg::csl_profile_type prof_q;
  logic [2:0]    sel;
  logic          pf_req_w;
  logic [15:0]   pf_addr_w;
  logic          port_rst_n;

  csl_flash_if fl ();

  // Restart also drops a read in flight, so no stale answer survives
  assign port_rst_n = RST_N && !FULL_RESTART; // RL7

  csl_flash_port u_port (
    .clk     (CORE_CLK),
    .rst_n   (port_rst_n),
    .fl      (fl),
    .pf_req  (pf_req_w),
    .pf_addr (pf_addr_w),
    .pf_ack  (PF_ACK),
    .pf_data (PF_DATA)
  );

  assign sel = fl.data[`CSL_SEL_LSB +: `CSL_SEL_W];

  // Record or profile word address
  always_comb
  begin
    fl.req  = rd_q;
    fl.addr = (state_q == ST_REC) ? `CSL_REC_ADDR
                                  : base_q + {8'h00, word_q};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N || FULL_RESTART) // RL1 RL7
    begin
      state_q   <= ST_RESET;
      word_q    <= 8'h00;
      base_q    <= `CSL_FACTORY_BASE;
      rd_q      <= 1'b0;
      prof_q    <= csl_pkg::CSL_PROFILE_FACTORY;
    end
    else
    begin
      unique case (state_q)
        ST_RESET: state_q <= ST_CHECK; // RL2
        ST_CHECK:
          if (IMG_DONE)
            state_q <= IMG_VALID ? ST_LOAD : ST_FAIL; // RL2 RL8
        ST_LOAD:
          if (IMG_LOADED)
          begin
            state_q <= ST_REC; // RL3
            rd_q    <= 1'b1;
          end
        ST_FAIL: state_q <= ST_FAIL; // RL8
        ST_REC:
          if (fl.ack)
          begin
            rd_q  <= 1'b1;
            state_q <= ST_SET;
            // Out-of-range selectors fall back to the factory profile
            if (sel >= `CSL_SEL_USER0 && sel <= `CSL_SEL_USER3) // RL4 RL5
            begin
              prof_q <= csl_pkg::csl_profile_type'(sel);
              base_q <= `CSL_USER_BASE
                      + `CSL_USER_STRIDE * {13'h0000, sel - 3'h1};
            end
            else
            begin
              prof_q <= csl_pkg::CSL_PROFILE_FACTORY; // RL5
              base_q <= `CSL_FACTORY_BASE;
            end
          end
          else
            rd_q <= 1'b0;
        ST_SET:
          if (fl.ack)
          begin
            if (word_q == `CSL_PROFILE_WORDS - 8'h01)
            begin
              state_q <= ST_READY; // RL6
              rd_q    <= 1'b0;
            end
            else
            begin
              word_q <= word_q + 8'h01;
              rd_q   <= 1'b1;
            end
          end
          else
            rd_q <= 1'b0;
        ST_READY: state_q <= ST_READY;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N || FULL_RESTART)
    begin
      IMG_CHECK  <= 1'b0;
      IMG_LOAD   <= 1'b0;
      PF_REQ     <= 1'b0;
      PF_ADDR    <= 16'h0000;
      SET_WE     <= 1'b0;
      SET_IDX    <= 8'h00;
      SET_DATA   <= 16'h0000;
      PROFILE    <= 3'h0;
      LINK_RST_N <= 1'b0; // RL7
      HEAD_RST_N <= 1'b0; // RL7
      BOOT_FAIL  <= 1'b0;
      CMD_ENABLE <= 1'b0;
    end
    else
    begin
      IMG_CHECK  <= (state_q == ST_CHECK);
      IMG_LOAD   <= (state_q == ST_LOAD);
      PF_REQ     <= pf_req_w;
      PF_ADDR    <= pf_addr_w;
      SET_WE     <= (state_q == ST_SET) && fl.ack; // RL4
      SET_IDX    <= word_q;
      SET_DATA   <= fl.data;
      PROFILE    <= prof_q;
      LINK_RST_N <= 1'b1;
      HEAD_RST_N <= (state_q != ST_CHECK) && (state_q != ST_RESET);
      BOOT_FAIL  <= (state_q == ST_FAIL); // RL8
      CMD_ENABLE <= (state_q == ST_READY); // RL6
    end
  end

  sequence restart_s;
    FULL_RESTART;
  endsequence

  restart_clears_a: assert property (@(posedge CORE_CLK) // RL7
    restart_s |=> !CMD_ENABLE && !LINK_RST_N && !HEAD_RST_N)
    else $error("restart did not reset");
  restart_check_a: assert property (@(posedge CORE_CLK) // RL1
    restart_s ##1 !FULL_RESTART && RST_N |=> state_q == ST_CHECK)
    else $error("restart did not recheck image");
  fail_no_load_a: assert property (@(posedge CORE_CLK) // RL8
    disable iff (!RST_N)
    state_q == ST_FAIL |-> !SET_WE && !CMD_ENABLE && !PF_REQ)
    else $error("restore after bad image");
  fail_sticks_a: assert property (@(posedge CORE_CLK) // RL8
    disable iff (!RST_N || FULL_RESTART)
    state_q == ST_FAIL |=> state_q == ST_FAIL)
    else $error("left boot loader");
  rec_first_a: assert property (@(posedge CORE_CLK) // RL3
    disable iff (!RST_N)
    state_q == ST_SET |-> $past(state_q) inside {ST_SET, ST_REC})
    else $error("settings before record");
  cmd_late_a: assert property (@(posedge CORE_CLK) // RL6
    disable iff (!RST_N)
    $rose(CMD_ENABLE) |-> $past(state_q) == ST_READY)
    else $error("commands before restore done");
  valid_load_a: assert property (@(posedge CORE_CLK) // RL2
    disable iff (!RST_N || FULL_RESTART)
    state_q == ST_CHECK && IMG_DONE && IMG_VALID |=> state_q == ST_LOAD)
    else $error("valid image not loaded");
  prof_range_a: assert property (@(posedge CORE_CLK) // RL5
    disable iff (!RST_N)
    PROFILE <= 3'h4)
    else $error("profile out of range");
  user_base_a: assert property (@(posedge CORE_CLK) // RL4
    disable iff (!RST_N || FULL_RESTART)
    state_q == ST_REC && fl.ack && sel == 3'h2 |=> base_q == 16'h0300)
    else $error("wrong profile space");

  // Load request rises two edges after a valid check result
  load_valid_a: assert property (@(posedge CORE_CLK) // RL2
    disable iff (!RST_N || FULL_RESTART)
    $rose(IMG_LOAD) |-> $past(IMG_DONE, 2) && $past(IMG_VALID, 2))
    else $error("image loaded without valid check");
  rec_addr_a: assert property (@(posedge CORE_CLK) // RL3
    disable iff (!RST_N || FULL_RESTART)
    state_q == ST_REC && PF_REQ |-> PF_ADDR == `CSL_REC_ADDR)
    else $error("record read from wrong address");
  cmd_no_write_a: assert property (@(posedge CORE_CLK) // RL6
    disable iff (!RST_N)
    SET_WE |-> !CMD_ENABLE)
    else $error("settings written after commands open");
  fail_quiet_a: assert property (@(posedge CORE_CLK) // RL8
    disable iff (!RST_N || FULL_RESTART)
    BOOT_FAIL |-> !IMG_LOAD && !CMD_ENABLE)
    else $error("boot loader left after bad image");
endmodule : csl_loader

// >>> csl_far_model.sv
`timescale 1ns/1ns
// Image store and parameter flash behind the loader
module csl_far_model (
  input  wire logic        clk,    // Core clock
  input  wire logic        img_ok, // Image store holds a good image
  input  wire logic        slow,   // Answer after five cycles
  input  wire logic [15:0] rec,    // Startup-source record word
  input  wire logic        chk,    // Check request
  output logic             done,   // Check finished
  output logic             valid,  // Image valid
  input  wire logic        load,   // Load request
  output logic             loaded, // Load finished
  input  wire logic        req,    // Flash read strobe
  input  wire logic [15:0] addr,   // Flash address
  output logic             ack,    // Flash data valid
  output logic [15:0]      data    // Flash data
);
  int cnt = 0;
  initial
  begin
    {done, valid, loaded, ack} = 4'h0;
    data = 16'h0000;
  end
  always @(posedge clk)
  begin
    {done, loaded, ack} <= 3'h0;
    // Released bus toggles so stale data never looks valid
    data <= ~data;
    cnt <= (chk | load | req) ? cnt + 1 : 0;
    if ((chk | load | req) && cnt == (slow ? 5 : 1))
    begin
      cnt <= 0;
      done <= chk;
      valid <= img_ok;
      loaded <= load & ~chk;
      ack <= req & ~chk & ~load;
      data <= (addr == 16'h0000) ? rec : (addr ^ 16'h5A5A);
    end
  end
endmodule : csl_far_model

// >>> camera_startup_loader_tb_top.sv
`timescale 1ns/1ns
`include "csl_regs.svh"
module camera_startup_loader_tb_top;
  logic clk = 0, rst_n = 0, rst_cmd = 0, img_ok = 1, slow = 0;
  logic [15:0] rec = 16'h0000, exp_base = 16'h0000, pf_addr, pf_data;
  logic chk, done, valid, load, loaded, req, ack, we, lrn, hrn, fail, en;
  logic [7:0] idx;
  logic [15:0] sdat;
  logic [2:0] prof;
  int n_errors = 0, total_checks = 0, n_we = 0, cyc = 0;
  always #4 clk = ~clk;
  csl_loader u_csl_loader (.CORE_CLK(clk), .RST_N(rst_n),
    .FULL_RESTART(rst_cmd), .IMG_CHECK(chk), .IMG_DONE(done),
    .IMG_VALID(valid), .IMG_LOAD(load), .IMG_LOADED(loaded), .PF_REQ(req),
    .PF_ADDR(pf_addr), .PF_ACK(ack), .PF_DATA(pf_data), .SET_WE(we),
    .SET_IDX(idx), .SET_DATA(sdat), .PROFILE(prof), .LINK_RST_N(lrn),
    .HEAD_RST_N(hrn), .BOOT_FAIL(fail), .CMD_ENABLE(en));
  csl_far_model u_csl_far_model (.clk(clk), .img_ok(img_ok), .slow(slow),
    .rec(rec), .chk(chk), .done(done), .valid(valid), .load(load),
    .loaded(loaded), .req(req), .addr(pf_addr), .ack(ack), .data(pf_data));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
  begin
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : check
  task print_verdict;
  begin
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask : print_verdict
  always @(posedge clk)
  begin
    if (we === 1'b1)
    begin
      check("set_idx", n_we[15:0], {8'h00, idx});
      check("set_data", (exp_base + n_we[15:0]) ^ 16'h5A5A, sdat);
      n_we++;
    end
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic wait_end();
  begin
    for (int i = 0; i < 2000 && en !== 1'b1 && fail !== 1'b1; i++)
      @(negedge clk);
  end
  endtask : wait_end
  task automatic boot_profile(input logic [2:0] sel, input logic s);
    logic [2:0] p;
  begin
    p = (sel > 3'h4) ? 3'h0 : sel;
    exp_base = (p == 3'h0) ? `CSL_FACTORY_BASE
             : `CSL_USER_BASE + `CSL_USER_STRIDE * (p - 3'h1);
    @(negedge clk);
    rec = {13'h0000, sel};
    slow = s;
    rst_n = 0;
    n_we = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    check("cmd_en_early", 16'h0000, {15'h0000, en});
    wait_end();
    check("cmd_en", 16'h0001, {15'h0000, en});
    check("boot_ok", 16'h0000, {15'h0000, fail});
    check("link_up", 16'h0001, {15'h0000, lrn});
    check("head_up", 16'h0001, {15'h0000, hrn});
    check("profile", {13'h0000, p}, {13'h0000, prof});
    check("words", {8'h00, `CSL_PROFILE_WORDS}, n_we[15:0]);
    $display("test profile %0d done", sel);
  end
  endtask : boot_profile
  task automatic restart_mid();
  begin
    repeat (60) @(negedge clk);
    // Second restart lands in mid-restore
    for (int k = 0; k < 2; k++)
    begin
      rst_cmd = 1;
      @(negedge clk);
      rst_cmd = 0;
      n_we = 0;
      check("link_rst", 16'h0000, {15'h0000, lrn});
      check("head_rst", 16'h0000, {15'h0000, hrn});
      check("cmd_off", 16'h0000, {15'h0000, en});
      if (k == 0)
        repeat (40) @(negedge clk);
    end
    wait_end();
    check("cmd_again", 16'h0001, {15'h0000, en});
    check("words_again", {8'h00, `CSL_PROFILE_WORDS}, n_we[15:0]);
    $display("test restart done");
  end
  endtask : restart_mid
  task automatic bad_image();
  begin
    @(negedge clk);
    img_ok = 0;
    rst_n = 0;
    n_we = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    wait_end();
    repeat (50) @(negedge clk);
    check("boot_fail", 16'h0001, {15'h0000, fail});
    check("cmd_stuck", 16'h0000, {15'h0000, en});
    check("no_read", 16'h0000, {15'h0000, req});
    check("no_check", 16'h0000, {15'h0000, chk});
    check("no_load", 16'h0000, {15'h0000, load});
    check("no_words", 16'h0000, n_we[15:0]);
    $display("test bad image done");
  end
  endtask : bad_image
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    for (int s = 0; s < 6; s++)
      boot_profile(s[2:0], s[0]);
    restart_mid();
    bad_image();
    print_verdict();
  end
endmodule : camera_startup_loader_tb_top
